// File: rtl/metering_register_bank_low.sv
// Purpose: Low register bank of an energy meter behind a byte-level serial port.
// Assumes: Port strobes come from serial framing logic on the same clock.
// Notes:   Reads snapshot the register at the command byte.
//
// How it works
// - Sample register holds channel 1, channel 2 or active power per mode bits.
// - Signed 24-bit active energy sum, zero after reset.
// - Active energy copy at 0x03 clears on each completed read.
// - Active power summed over the programmed number of half line cycles.
// - Unsigned 24-bit apparent energy sum, zero after reset.
// - Apparent energy copy at 0x06 clears on each completed read.
// - Apparent power summed over the programmed number of half line cycles.
// - Mode register, 16 bits, resets to 0x000c, readable any time.
// - Enable bits gate events onto the interrupt output; status still records.
// - Read-only 16-bit status register, resets to zero.
// - Status mirror at 0x0c; flags clear after it is read.
// - Channel 1 offset in bits 5:0, bit 6 unused, bit 7 integrator enable.
// - Channel 2 offset bits 5:0 apply inverted; bits 7:6 unused.
// - Amplifier gain select, 8 bits, resets to zero.
// - Signed 16-bit offset subtracted from active power fed to the energy sums; sample register takes it raw.
// - Command byte: MSB write flag, six low bits address.
// - A read captures the whole register at once.
// - Bytes go MSB first, right justified; excess high bits ignored.
`timescale 1ns/1ps
module metering_register_bank_low
  import metering_regs_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        cmd_valid_i,
  input  wire logic [7:0]  cmd_byte_i,
  input  wire logic        wr_valid_i,
  input  wire logic [7:0]  wr_byte_i,
  input  wire logic        rd_req_i,
  input  wire logic        abort_i,
  output logic      [7:0]  rd_byte_o,
  output logic             rd_valid_o,
  output logic             xfer_busy_o,
  input  wire logic        sample_valid_i,
  input  wire logic [23:0] ch1_sample_i,
  input  wire logic [23:0] ch2_sample_i,
  input  wire logic [23:0] active_power_i,
  input  wire logic [23:0] apparent_power_i,
  input  wire logic        half_cycle_i,
  input  wire logic [15:0] half_cycle_count_i,
  input  wire logic [15:0] irq_event_i,
  output logic      [15:0] mode_o,
  output logic             integrator_en_o,
  output logic      [5:0]  ch1_offset_o,
  output logic      [5:0]  ch2_offset_o,
  output logic      [7:0]  gain_o,
  output logic      [5:0]  phase_cal_o,
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  port_state_t  state_reg;
  logic [5:0]   addr_reg;
  logic [1:0]   bytes_left_reg;
  logic [23:0]  xfer_reg;
  logic [7:0]   rd_byte_reg;
  logic         rd_valid_reg;
  logic [15:0]  mode_reg;
  logic [15:0]  irq_en_reg;
  logic [15:0]  status_reg;
  logic [15:0]  status_next;
  logic         irq_reg;
  logic [7:0]   ch1_ofs_reg;
  logic [7:0]   ch2_ofs_reg;
  logic [5:0]   ch2_applied_reg;
  logic [7:0]   gain_reg;
  logic [5:0]   phase_calibration_reg;
  logic [15:0]  active_power_offset_reg;
  logic [23:0]  sample_reg;
  logic [23:0]  act_total;
  logic [23:0]  act_rc;
  logic [23:0]  act_line;
  logic [23:0]  app_total;
  logic [23:0]  app_rc;
  logic [23:0]  app_line;
  logic [23:0]  act_power_adj;
  logic [23:0]  read_value;
  logic [23:0]  read_aligned;
  logic [23:0]  wr_value;
  logic [5:0]   cmd_addr;
  logic         cmd_take;
  logic         rd_step;
  logic         wr_step;
  logic         last_byte;
  logic         rd_done;
  logic         wr_commit;

  assign cmd_addr  = cmd_byte_i[CMD_ADDR_W-1:0];
  assign cmd_take  = state_reg == ST_COMMAND && cmd_valid_i && !abort_i;
  assign rd_step   = state_reg == ST_READ && rd_req_i && !abort_i;
  assign wr_step   = state_reg == ST_WRITE && wr_valid_i && !abort_i;
  assign last_byte = bytes_left_reg == BYTES_1;
  assign rd_done   = rd_step && last_byte;
  assign wr_commit = wr_step && last_byte;
  assign wr_value  = {xfer_reg[15:0], wr_byte_i};

  assign rd_byte_o       = rd_byte_reg;
  assign rd_valid_o      = rd_valid_reg;
  assign xfer_busy_o     = state_reg != ST_COMMAND;
  assign mode_o          = mode_reg;
  assign integrator_en_o = ch1_ofs_reg[INTEG_BIT];
  assign ch1_offset_o    = ch1_ofs_reg[OFS_W-1:0];
  assign ch2_offset_o    = ch2_applied_reg;
  assign gain_o          = gain_reg;
  assign phase_cal_o     = phase_calibration_reg;
  assign irq_o           = irq_reg;

  // ----------------------------------------------------------------
  // Read mux and alignment
  // ----------------------------------------------------------------
  // Unmapped and reserved addresses read as zero
  always_comb
  begin
    read_value = '0;
    case (cmd_addr)
      ADDR_SAMPLE:    read_value = sample_reg;
      ADDR_ACT:       read_value = act_total;
      ADDR_ACT_RC:    read_value = act_rc;
      ADDR_ACT_LINE:  read_value = act_line;
      ADDR_APP:       read_value = app_total;
      ADDR_APP_RC:    read_value = app_rc;
      ADDR_APP_LINE:  read_value = app_line;
      ADDR_MODE:      read_value = {8'h00, mode_reg};
      ADDR_IRQ_EN:    read_value = {8'h00, irq_en_reg};
      ADDR_STATUS:    read_value = {8'h00, status_reg};
      ADDR_STATUS_RC: read_value = {8'h00, status_reg};
      ADDR_CH1_OFS:   read_value = {16'h0000, ch1_ofs_reg};
      ADDR_CH2_OFS:   read_value = {16'h0000, ch2_ofs_reg};
      ADDR_GAIN:      read_value = {16'h0000, gain_reg};
      ADDR_PHASE_CALIBRATION:     read_value = {18'h00000, phase_calibration_reg};
      ADDR_ACTIVE_POWER_OFFSET:      read_value = {8'h00, active_power_offset_reg};
      default:        read_value = '0;
    endcase
  end

  always_comb
  begin
    read_aligned = read_value;
    case (reg_bytes(cmd_addr))
      BYTES_2: read_aligned = {read_value[15:0], 8'h00};
      BYTES_1: read_aligned = {read_value[7:0], 16'h0000};
      default: read_aligned = read_value;
    endcase
  end

  // ----------------------------------------------------------------
  // Serial port byte sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_reg      <= ST_COMMAND;
      addr_reg       <= '0;
      bytes_left_reg <= '0;
      xfer_reg       <= '0;
    end
    else if (abort_i)
    begin
      state_reg      <= ST_COMMAND;
      bytes_left_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        ST_COMMAND:
          if (cmd_valid_i)
          begin
            addr_reg       <= cmd_addr;
            bytes_left_reg <= reg_bytes(cmd_addr);
            if (cmd_byte_i[CMD_RW_BIT])
            begin
              state_reg <= ST_WRITE;
              xfer_reg  <= '0;
            end
            else
            begin
              state_reg <= ST_READ;
              xfer_reg  <= read_aligned;
            end
          end
        ST_READ:
          if (rd_req_i)
          begin
            xfer_reg       <= {xfer_reg[15:0], 8'h00};
            bytes_left_reg <= bytes_left_reg - BYTES_1;
            if (last_byte)
              state_reg <= ST_COMMAND;
          end
        ST_WRITE:
          if (wr_valid_i)
          begin
            xfer_reg       <= wr_value;
            bytes_left_reg <= bytes_left_reg - BYTES_1;
            if (last_byte)
              state_reg <= ST_COMMAND;
          end
        default:
          state_reg <= ST_COMMAND;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rd_byte_reg  <= '0;
      rd_valid_reg <= 1'b0;
    end
    else
    begin
      rd_valid_reg <= rd_step;
      if (rd_step)
        rd_byte_reg <= xfer_reg[23:16];
    end
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  // Read-only and reserved addresses fall through untouched
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mode_reg        <= MODE_RESET;
      irq_en_reg      <= IRQ_EN_RESET;
      ch1_ofs_reg     <= '0;
      ch2_ofs_reg     <= '0;
      ch2_applied_reg <= '0;
      gain_reg        <= '0;
      phase_calibration_reg       <= PHASE_CALIBRATION_RESET;
      active_power_offset_reg        <= '0;
    end
    else if (wr_commit)
    begin
      case (addr_reg)
        ADDR_MODE:    mode_reg   <= wr_value[15:0];
        ADDR_IRQ_EN:  irq_en_reg <= wr_value[15:0];
        ADDR_CH1_OFS: ch1_ofs_reg <= {wr_value[INTEG_BIT], 1'b0, wr_value[OFS_W-1:0]};
        ADDR_CH2_OFS:
        begin
          ch2_ofs_reg     <= {2'b00, wr_value[OFS_W-1:0]};
          ch2_applied_reg <= 6'h00 - wr_value[OFS_W-1:0];
        end
        ADDR_GAIN:    gain_reg  <= wr_value[7:0];
        ADDR_PHASE_CALIBRATION:   phase_calibration_reg <= wr_value[OFS_W-1:0];
        ADDR_ACTIVE_POWER_OFFSET:    active_power_offset_reg  <= wr_value[15:0];
        default:      ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sample capture and energy datapath
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      sample_reg <= '0;
    else if (sample_valid_i)
    begin
      case (mode_reg[SRC_HI:SRC_LO])
        SRC_CH1: sample_reg <= ch1_sample_i;
        SRC_CH2: sample_reg <= ch2_sample_i;
        default: sample_reg <= active_power_i;
      endcase
    end
  end

  assign act_power_adj = active_power_i - {{8{active_power_offset_reg[15]}}, active_power_offset_reg};

  energy_accumulator #(.ACC_W(REG24_W), .CNT_W(REG16_W)) u_active
  (
    .sys_clk_i          (sys_clk_i),
    .nrst_i             (nrst_i),
    .add_i              (sample_valid_i),
    .power_i            (act_power_adj),
    .clear_i            (rd_done && addr_reg == ADDR_ACT_RC),
    .half_cycle_i       (half_cycle_i),
    .half_cycle_count_i (half_cycle_count_i),
    .total_o            (act_total),
    .read_clear_o       (act_rc),
    .line_o             (act_line)
  );

  energy_accumulator #(.ACC_W(REG24_W), .CNT_W(REG16_W)) u_apparent
  (
    .sys_clk_i          (sys_clk_i),
    .nrst_i             (nrst_i),
    .add_i              (sample_valid_i),
    .power_i            (apparent_power_i),
    .clear_i            (rd_done && addr_reg == ADDR_APP_RC),
    .half_cycle_i       (half_cycle_i),
    .half_cycle_count_i (half_cycle_count_i),
    .total_o            (app_total),
    .read_clear_o       (app_rc),
    .line_o             (app_line)
  );

  // ----------------------------------------------------------------
  // Interrupt status and request
  // ----------------------------------------------------------------
  // New events beat the clear so none is lost
  assign status_next = ((rd_done && addr_reg == ADDR_STATUS_RC) ? 16'h0000 : status_reg)
                       | irq_event_i;

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      status_reg <= '0;
      irq_reg    <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      irq_reg    <= |(status_next & irq_en_reg);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  AST_SAMPLE_CH1: assert property (
    sample_valid_i && mode_reg[SRC_HI:SRC_LO] == SRC_CH1 |=> sample_reg == $past(ch1_sample_i))
    else $error("sample register missed channel 1");
  AST_ACT_RC_CLEAR: assert property (
    rd_done && addr_reg == ADDR_ACT_RC && !sample_valid_i |=> act_rc == 24'h000000)
    else $error("active read-clear copy not cleared");
  AST_APP_RC_CLEAR: assert property (
    rd_done && addr_reg == ADDR_APP_RC && !sample_valid_i |=> app_rc == 24'h000000)
    else $error("apparent read-clear copy not cleared");
  AST_STATUS_CLEAR: assert property (
    rd_done && addr_reg == ADDR_STATUS_RC && irq_event_i == 16'h0000 |=> status_reg == 16'h0000)
    else $error("status not cleared after mirror read");
  AST_IRQ_GATE: assert property (
    irq_event_i != 16'h0000 && (irq_event_i & irq_en_reg) == 16'h0000 &&
    (status_reg & irq_en_reg) == 16'h0000 |=> !irq_o ##0 (status_reg & $past(irq_event_i)) != 16'h0000)
    else $error("masked event drove the request or was not recorded");
  AST_MODE_WRITE: assert property (
    wr_commit && addr_reg == ADDR_MODE |=> mode_o == $past(wr_value[15:0]))
    else $error("mode register write lost");
  AST_RO_IGNORED: assert property (
    wr_commit && addr_reg <= ADDR_RESERVED |=> $stable(mode_reg) && $stable(irq_en_reg) &&
    $stable(active_power_offset_reg) && $stable(gain_reg))
    else $error("write to read-only address changed a register");
  AST_CH2_INVERT: assert property (
    wr_commit && addr_reg == ADDR_CH2_OFS |=> ch2_offset_o + $past(wr_value[5:0]) == 6'h00)
    else $error("channel 2 offset not inverted");
  AST_READ_SNAPSHOT: assert property (
    cmd_take && !cmd_byte_i[CMD_RW_BIT] && reg_bytes(cmd_addr) == BYTES_3
    |=> xfer_reg == $past(read_value) && bytes_left_reg == BYTES_3)
    else $error("read did not capture the whole register");
  AST_ABORT_NO_CLEAR: assert property (
    state_reg == ST_READ && abort_i && addr_reg == ADDR_STATUS_RC && irq_event_i == 16'h0000
    |=> state_reg == ST_COMMAND && status_reg == $past(status_reg))
    else $error("aborted read cleared status");

endmodule

// File: pkg/metering_regs_pkg.sv
// Purpose: Shared constants for the low metering register bank.
// Assumes: 6-bit register addresses, byte-wide serial port transfers.
// Notes:   Widths and byte counts follow each register's printed size.
package metering_regs_pkg;

  // ----------------------------------------------------------------
  // Addresses
  // ----------------------------------------------------------------
  localparam int          CMD_ADDR_W      = 6;
  localparam int          CMD_RW_BIT      = 7;
  localparam logic [5:0]  ADDR_SAMPLE     = 6'h01;
  localparam logic [5:0]  ADDR_ACT        = 6'h02;
  localparam logic [5:0]  ADDR_ACT_RC     = 6'h03;
  localparam logic [5:0]  ADDR_ACT_LINE   = 6'h04;
  localparam logic [5:0]  ADDR_APP        = 6'h05;
  localparam logic [5:0]  ADDR_APP_RC     = 6'h06;
  localparam logic [5:0]  ADDR_APP_LINE   = 6'h07;
  localparam logic [5:0]  ADDR_RESERVED   = 6'h08;
  localparam logic [5:0]  ADDR_MODE       = 6'h09;
  localparam logic [5:0]  ADDR_IRQ_EN     = 6'h0a;
  localparam logic [5:0]  ADDR_STATUS     = 6'h0b;
  localparam logic [5:0]  ADDR_STATUS_RC  = 6'h0c;
  localparam logic [5:0]  ADDR_CH1_OFS    = 6'h0d;
  localparam logic [5:0]  ADDR_CH2_OFS    = 6'h0e;
  localparam logic [5:0]  ADDR_GAIN       = 6'h0f;
  localparam logic [5:0]  ADDR_PHASE_CALIBRATION      = 6'h10;
  localparam logic [5:0]  ADDR_ACTIVE_POWER_OFFSET       = 6'h11;

  // ----------------------------------------------------------------
  // Widths, fields and reset values
  // ----------------------------------------------------------------
  localparam int          REG24_W         = 24;
  localparam int          REG16_W         = 16;
  localparam int          OFS_W           = 6;
  localparam int          INTEG_BIT       = 7;
  localparam int          SRC_HI          = 14;
  localparam int          SRC_LO          = 13;
  localparam logic [1:0]  SRC_CH1         = 2'h2;
  localparam logic [1:0]  SRC_CH2         = 2'h3;
  localparam logic [15:0] MODE_RESET      = 16'h000c;
  localparam logic [15:0] IRQ_EN_RESET    = 16'h0040;
  localparam logic [5:0]  PHASE_CALIBRATION_RESET     = 6'h0d;
  localparam logic [1:0]  BYTES_3         = 2'h3;
  localparam logic [1:0]  BYTES_2         = 2'h2;
  localparam logic [1:0]  BYTES_1         = 2'h1;

  typedef enum logic [1:0]
  {
    ST_COMMAND = 2'b00,
    ST_READ    = 2'b01,
    ST_WRITE   = 2'b10
  } port_state_t;

  // Data bytes that follow the command byte for each address
  function automatic logic [1:0] reg_bytes(input logic [5:0] a);
    if (a >= ADDR_SAMPLE && a <= ADDR_APP_LINE)
      return BYTES_3;
    if (a == ADDR_MODE || a == ADDR_IRQ_EN || a == ADDR_STATUS ||
        a == ADDR_STATUS_RC || a == ADDR_ACTIVE_POWER_OFFSET)
      return BYTES_2;
    return BYTES_1;
  endfunction

endpackage

// File: rtl/energy_accumulator.sv
// Purpose: Energy accumulator with read-clear copy and line-cycle window.
// Assumes: Power samples are already at accumulator width; sums wrap.
// Notes:   A sample that lands on a clear is kept in the fresh sum.
`timescale 1ns/1ps
module energy_accumulator
  import metering_regs_pkg::*;
#(
  parameter int ACC_W = REG24_W,
  parameter int CNT_W = REG16_W
)
(
  input  wire logic             sys_clk_i,
  input  wire logic             nrst_i,
  input  wire logic             add_i,
  input  wire logic [ACC_W-1:0] power_i,
  input  wire logic             clear_i,
  input  wire logic             half_cycle_i,
  input  wire logic [CNT_W-1:0] half_cycle_count_i,
  output logic      [ACC_W-1:0] total_o,
  output logic      [ACC_W-1:0] read_clear_o,
  output logic      [ACC_W-1:0] line_o
);

  if (ACC_W < 8 || CNT_W < 1)
  begin : g_chk
    $error("energy_accumulator: unsupported widths");
  end

  logic [ACC_W-1:0] inc;
  logic [ACC_W-1:0] total_reg;
  logic [ACC_W-1:0] rc_reg;
  logic [ACC_W-1:0] line_reg;
  logic [ACC_W-1:0] line_sum_reg;
  logic [CNT_W-1:0] hc_cnt_reg;
  logic [CNT_W:0]   hc_plus;

  assign inc          = add_i ? power_i : '0;
  assign hc_plus      = {1'b0, hc_cnt_reg} + (CNT_W+1)'(1);
  assign total_o      = total_reg;
  assign read_clear_o = rc_reg;
  assign line_o       = line_reg;

  // ----------------------------------------------------------------
  // Running and read-clear sums
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      total_reg <= '0;
    else
      total_reg <= total_reg + inc;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rc_reg <= '0;
    else if (clear_i)
      rc_reg <= inc;
    else
      rc_reg <= rc_reg + inc;
  end

  // ----------------------------------------------------------------
  // Line-cycle window
  // ----------------------------------------------------------------
  // A zero count behaves as one, so the window never stalls
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      line_reg     <= '0;
      line_sum_reg <= '0;
      hc_cnt_reg   <= '0;
    end
    else if (half_cycle_i && hc_plus >= {1'b0, half_cycle_count_i})
    begin
      line_reg     <= line_sum_reg + inc;
      line_sum_reg <= '0;
      hc_cnt_reg   <= '0;
    end
    else
    begin
      line_sum_reg <= line_sum_reg + inc;
      if (half_cycle_i)
        hc_cnt_reg <= hc_plus[CNT_W-1:0];
    end
  end

  AST_ACC_INTEGRATES: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    add_i |=> total_o == $past(total_o) + $past(power_i))
    else $error("accumulator did not add the power sample");

endmodule

// File: verification/host_port_model.sv
// Purpose: Host side of the byte-level register port.
// Assumes: Strobes launched by NBA at a rising edge, taken at the next.
// Notes:   A read that times out returns unknowns so the compare fails.
`timescale 1ns/1ps
module host_port_model
  import metering_regs_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] rd_byte_i,
  input  wire logic       rd_valid_i,
  output logic            cmd_valid_o = 1'b0,
  output logic      [7:0] cmd_byte_o  = 8'h00,
  output logic            wr_valid_o  = 1'b0,
  output logic      [7:0] wr_byte_o   = 8'h00,
  output logic            rd_req_o    = 1'b0,
  output logic            abort_o     = 1'b0
);
  task automatic send_cmd(input logic rw, input logic [5:0] a);
    @(posedge sys_clk_i);
    cmd_valid_o <= 1'b1;
    cmd_byte_o  <= {rw, 1'b0, a};
    @(posedge sys_clk_i);
    cmd_valid_o <= 1'b0;
  endtask

  task automatic write_reg(input logic [5:0] a, input logic [23:0] d);
    int n;
    n = int'(reg_bytes(a));
    // Out-of-range phase values are never sent
    if (a == ADDR_PHASE_CALIBRATION && (d[5:0] < 6'h1d || d[5:0] > 6'h21))
      return;
    send_cmd(1'b1, a);
    for (int i = n - 1; i >= 0; i--)
    begin
      wr_valid_o <= 1'b1;
      wr_byte_o  <= d[8*i +: 8];
      @(posedge sys_clk_i);
    end
    wr_valid_o <= 1'b0;
  endtask

  task automatic read_reg(input logic [5:0] a, output logic [23:0] d, input int stop = 9);
    int n;
    int k;
    n = int'(reg_bytes(a));
    d = '0;
    send_cmd(1'b0, a);
    for (int i = 0; i < n; i++)
    begin
      if (i == stop)
      begin
        abort_o <= 1'b1;
        @(posedge sys_clk_i);
        abort_o <= 1'b0;
        return;
      end
      rd_req_o <= 1'b1;
      @(posedge sys_clk_i);
      rd_req_o <= 1'b0;
      k = 0;
      do @(posedge sys_clk_i); while (rd_valid_i !== 1'b1 && ++k < 4);
      if (k == 4)
        d = 'x;
      else
        d = {d[15:0], rd_byte_i};
    end
  endtask
endmodule

// File: verification/metering_register_bank_low_tb.sv
// Purpose: Self-checking bench for the low metering register bank.
// Assumes: Host model drives the port; bench drives the datapath.
// Notes:   Line window test uses a count of one half cycle.
`timescale 1ns/1ps
module metering_register_bank_low_tb;
  import metering_regs_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cv, wv, rq, ab, rv, sv = 1'b0, hc = 1'b0, ien, irq, bsy;
  logic [7:0]  cb, wb, rb, gain;
  logic [23:0] c1 = 24'h123456, c2 = 24'h0abcde, ap = '0, sp = '0;
  logic [15:0] hcc = 16'h0001, ev = '0, mode;
  logic [5:0]  o1, o2, ph;
  int          fail_count = 0;
  int          checks = 0;

  always #2.5 clk = ~clk;

  metering_register_bank_low uut (.sys_clk_i(clk), .nrst_i(nrst), .cmd_valid_i(cv),
    .cmd_byte_i(cb), .wr_valid_i(wv), .wr_byte_i(wb), .rd_req_i(rq), .abort_i(ab),
    .rd_byte_o(rb), .rd_valid_o(rv), .xfer_busy_o(bsy), .sample_valid_i(sv),
    .ch1_sample_i(c1), .ch2_sample_i(c2), .active_power_i(ap), .apparent_power_i(sp),
    .half_cycle_i(hc), .half_cycle_count_i(hcc), .irq_event_i(ev), .mode_o(mode),
    .integrator_en_o(ien), .ch1_offset_o(o1), .ch2_offset_o(o2), .gain_o(gain),
    .phase_cal_o(ph), .irq_o(irq));

  host_port_model host (.sys_clk_i(clk), .rd_byte_i(rb), .rd_valid_i(rv),
    .cmd_valid_o(cv), .cmd_byte_o(cb), .wr_valid_o(wv), .wr_byte_o(wb),
    .rd_req_o(rq), .abort_o(ab));

  task automatic end_of_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rchk(input string nm, input logic [5:0] a, input logic [23:0] e);
    logic [23:0] v;
    host.read_reg(a, v);
    chk(nm, e, v);
  endtask

  task automatic pulse(input logic [23:0] p, input logic [23:0] q, input logic [15:0] e);
    @(posedge clk);
    sv <= (e == '0);
    ap <= p;
    sp <= q;
    ev <= e;
    @(posedge clk);
    sv <= 1'b0;
    ev <= '0;
    repeat (2) @(posedge clk);
  endtask

  task automatic t_reset();
    rchk("mode", ADDR_MODE, 24'h00000c);
    rchk("irq_en", ADDR_IRQ_EN, 24'h000040);
    rchk("status", ADDR_STATUS, 24'h0);
    rchk("energy", ADDR_ACT, 24'h0);
    rchk("app", ADDR_APP, 24'h0);
    rchk("gain", ADDR_GAIN, 24'h0);
    chk("phase_cal_o", 24'h0d, ph);
    chk("xfer_busy_o", 24'h0, bsy);
  endtask

  task automatic t_rw();
    host.write_reg(ADDR_CH1_OFS, 24'h85);
    host.write_reg(ADDR_CH2_OFS, 24'hff);
    host.write_reg(ADDR_GAIN, 24'h5a);
    host.write_reg(ADDR_PHASE_CALIBRATION, 24'h1f);
    host.write_reg(ADDR_STATUS, 24'h1234);
    host.write_reg(ADDR_RESERVED, 24'h77);
    chk("integ", 24'h1, ien);
    chk("ch1_ofs", 24'h05, o1);
    chk("ch2_ofs", 24'h01, o2);
    chk("gain_o", 24'h5a, gain);
    rchk("ch2_rd", ADDR_CH2_OFS, 24'h3f);
    rchk("ro_wr", ADDR_STATUS, 24'h0);
    rchk("rsv", ADDR_RESERVED, 24'h0);
  endtask

  task automatic t_energy();
    logic [23:0] v;
    host.write_reg(ADDR_MODE, 24'h400c);
    pulse(24'h10, 24'h20, '0);
    pulse(24'h10, 24'h20, '0);
    rchk("wave1", ADDR_SAMPLE, 24'h123456);
    rchk("act", ADDR_ACT, 24'h20);
    rchk("act_rc", ADDR_ACT_RC, 24'h20);
    rchk("act_rc0", ADDR_ACT_RC, 24'h0);
    rchk("app_rc", ADDR_APP_RC, 24'h40);
    rchk("app_rc0", ADDR_APP_RC, 24'h0);
    pulse(24'h10, 24'h20, '0);
    host.read_reg(ADDR_ACT_RC, v, 1);
    rchk("abort", ADDR_ACT_RC, 24'h10);
    host.write_reg(ADDR_MODE, 24'h600c);
    pulse(24'h0, 24'h0, '0);
    rchk("wave2", ADDR_SAMPLE, 24'h0abcde);
    chk("mode_o", 24'h600c, mode);
  endtask

  task automatic t_irq();
    logic [23:0] v;
    pulse(24'h0, 24'h0, 16'h0001);
    chk("irq_off", 24'h0, irq);
    rchk("st", ADDR_STATUS, 24'h1);
    pulse(24'h0, 24'h0, 16'h0040);
    chk("irq_on", 24'h1, irq);
    host.read_reg(ADDR_STATUS_RC, v, 1);
    rchk("st_rc", ADDR_STATUS_RC, 24'h41);
    rchk("st_clr", ADDR_STATUS, 24'h0);
    chk("irq_clr", 24'h0, irq);
  endtask

  task automatic t_line();
    host.write_reg(ADDR_ACTIVE_POWER_OFFSET, 24'h0004);
    repeat (2)
    begin
      @(posedge clk);
      hc <= 1'b1;
      @(posedge clk);
      hc <= 1'b0;
      pulse(24'h10, 24'h20, '0);
    end
    rchk("act_line", ADDR_ACT_LINE, 24'h0c);
    rchk("app_line", ADDR_APP_LINE, 24'h20);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_of_test();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_rw();
    t_energy();
    t_irq();
    t_line();
    end_of_test();
  end
endmodule
